// ===== hdl/pos_supervisor.sv
// module: apb-controlled output supervisor with fault, power good and phase logic
`timescale 1ns/100ps
`default_nettype none
module pos_supervisor
    import pos_pkg::*;
#(
    parameter int HICCUP_CYCLES = HICCUP_CYC,
    parameter int SW_DIV        = SW_DIV_DEF
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  strap_code,
    input  wire logic        ctrl_pin,
    input  wire logic        ctrl_pin_open,
    input  wire pos_meas_t   meas,
    output logic             reg_en,
    output logic      [15:0] vout_set,
    output logic             pwm_a_start,
    output logic             pwm_b_start,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe_n,
    output logic             pg_out,
    output logic             pg_oe_n
);
    typedef struct packed {
        logic        init_done;
        logic        op_on;
        logic [1:0]  op_mrg;
        logic [1:0]  onoff;
        logic [15:0] vcmd;
        logic [15:0] trim;
        logic [15:0] vmax;
        logic [15:0] mlow;
        logic [15:0] mhigh;
        logic [15:0] ovl;
        logic [15:0] uvl;
        logic [15:0] pgon;
        logic [15:0] ocl;
        logic [15:0] ucl;
        logic [4:0]  resp;
        logic [15:0] pgdly;
        logic        pp;
        logic [1:0]  syncm;
        logic [7:0]  ilv;
        logic [15:0] strap_mv;
        logic [15:0] ceil115;
        pos_pwr_t    st;
        logic [3:0]  flt;
        logic [19:0] hic_cnt;
        logic [15:0] pg_cnt;
        logic        pg_ok;
        logic        pg;
        logic        pg_out;
        logic        pg_oe_n;
        logic [15:0] vapp;
        logic [31:0] prdata;
        logic        sync_prev;
        logic [15:0] per_cnt;
        logic [15:0] period;
        logic [23:0] acc;
        logic        fired_a;
        logic        fired_b;
        logic [15:0] int_cnt;
        logic        int_clk;
        logic        pwm_a;
        logic        pwm_b;
    } pos_state_t;

    pos_state_t r;
    pos_state_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // derived combinational terms
    logic        wr;
    logic        mapped;
    logic        pin_lvl;
    logic        en;
    logic [15:0] target;
    logic [15:0] ceil;
    logic [17:0] sum;
    logic [15:0] applied;
    logic        f_ov;
    logic        f_uv;
    logic        f_oc;
    logic        f_uc;
    logic [3:0]  f_now;
    logic        latch;
    logic        src;
    logic        rise;
    logic [4:0]  grp16;
    logic [5:0]  k_b;
    logic [23:0] tgt_a;
    logic [23:0] tgt_b;
    logic [31:0] rd_val;

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            OFS_OPERATION: rd_val = {29'h0000_0000, r.op_mrg, r.op_on};
            OFS_ONOFF:     rd_val = {30'h0000_0000, r.onoff};
            OFS_VCMD:      rd_val = {16'h0000, r.vcmd};
            OFS_TRIM:      rd_val = {16'h0000, r.trim};
            OFS_VMAX:      rd_val = {16'h0000, r.vmax};
            OFS_MLOW:      rd_val = {16'h0000, r.mlow};
            OFS_MHIGH:     rd_val = {16'h0000, r.mhigh};
            OFS_OVL:       rd_val = {16'h0000, r.ovl};
            OFS_UVL:       rd_val = {16'h0000, r.uvl};
            OFS_PGON:      rd_val = {16'h0000, r.pgon};
            OFS_OCL:       rd_val = {16'h0000, r.ocl};
            OFS_UCL:       rd_val = {16'h0000, r.ucl};
            OFS_RESP:      rd_val = {27'h000_0000, r.resp};
            OFS_PGDLY:     rd_val = {16'h0000, r.pgdly};
            OFS_USERCFG:   rd_val = {29'h0000_0000, r.syncm, r.pp};
            OFS_ILV:       rd_val = {24'h00_0000, r.ilv};
            OFS_STATUS:    rd_val = {20'h0_0000, 1'b0, 3'(r.st), r.flt, 2'h0, r.pg, r.init_done};
            OFS_CLEAR:     rd_val = 32'h0000_0000;
            OFS_VAPP:      rd_val = {16'h0000, r.vapp};
            default:       mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        // open pin is pulled high
        pin_lvl = ctrl_pin_open ? 1'b1 : ctrl_pin;
        // pin or bus enable, pin polarity selectable
        if (r.onoff[PIN_MODE_BIT])
            en = r.onoff[PIN_POL_BIT] ? pin_lvl : !pin_lvl;
        else
            en = r.op_on;
        // margin select regardless of enable source
        unique case (r.op_mrg)
            MRG_LOW:  target = r.mlow;
            MRG_HIGH: target = r.mhigh;
            default:  target = r.vcmd;
        endcase
        // ceiling can only be lowered by the max register
        ceil = (r.vmax < r.ceil115) ? r.vmax : r.ceil115;
        // trim added as signed value
        sum = 18'(target) + {{2{r.trim[15]}}, r.trim};
        // clamp applies to output only, stored values untouched
        if (sum[17])
            applied = 16'h0000;
        else if (sum[16:0] > 17'(ceil))
            applied = ceil;
        else
            applied = sum[15:0];
    end

    always_comb
    begin
        f_ov = (r.st == PW_RAMP || r.st == PW_ON) && (meas.vout_mv > r.ovl);
        f_uv = (r.st == PW_ON) && (meas.vout_mv < r.uvl);
        // current faults only once ramp-up is done
        f_oc = (r.st == PW_ON) && (meas.iout > $signed(r.ocl));
        f_uc = (r.st == PW_ON) && (meas.iout < -$signed(r.ucl));
        f_now = {f_uc, f_oc, f_uv, f_ov};
        // sharing forces latch-off; otherwise per-fault select
        latch = r.resp[RESP_SHARE] || |(f_now & r.resp[3:0]);
    end

    always_comb
    begin
        // internal clock unless pin configured as input
        src  = (r.syncm == SYNC_IN) ? sync_in : r.int_clk;
        rise = src && !r.sync_prev;
        // group of zero means sixteen
        grp16 = (r.ilv[7:GRP_LSB] == 4'h0) ? 5'h10 : {1'b0, r.ilv[7:GRP_LSB]};
        // lag = period * order / group, by accumulating group per tick
        tgt_a = 24'(r.period) * 24'(r.ilv[3:0]);
        // second phase half a period later
        k_b = 6'({r.ilv[3:0], 1'b0}) + 6'(grp16);
        if (k_b >= 6'({grp16, 1'b0}))
            k_b = k_b - 6'({grp16, 1'b0});
        tgt_b = 24'(r.period) * 24'(k_b);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        n       = r;
        n.pwm_a = 1'b0;
        n.pwm_b = 1'b0;

        // one-time strap capture and defaults
        if (!r.init_done)
        begin
            n.init_done = 1'b1;
            n.strap_mv  = pos_strap(strap_code);
            n.ceil115   = pos_pct(n.strap_mv, PCT_CEIL);
            n.vcmd      = n.strap_mv;
            n.vmax      = n.ceil115;
            n.mlow      = pos_pct(n.strap_mv, PCT_MLOW);
            n.mhigh     = pos_pct(n.strap_mv, PCT_MHIGH);
            n.ovl       = pos_pct(n.strap_mv, PCT_OV);
            n.uvl       = pos_pct(n.strap_mv, PCT_UV);
            n.pgon      = pos_pct(n.strap_mv, PCT_PGON);
        end

        if (psel && !penable)
            n.prdata = rd_val;

        // bus writes come after the init load and override it
        if (wr)
        begin
            unique case (paddr)
                OFS_OPERATION:
                begin
                    n.op_on  = pwdata[OP_ON_BIT];
                    n.op_mrg = pwdata[OP_MRG_LSB +: 2];
                end
                OFS_ONOFF:   n.onoff = pwdata[1:0];
                OFS_VCMD:    n.vcmd  = pwdata[15:0];
                OFS_TRIM:    n.trim  = pwdata[15:0];
                OFS_VMAX:    n.vmax  = pwdata[15:0];
                OFS_MLOW:    n.mlow  = pwdata[15:0];
                OFS_MHIGH:   n.mhigh = pwdata[15:0];
                OFS_OVL:     n.ovl   = pwdata[15:0];
                OFS_UVL:     n.uvl   = pwdata[15:0];
                OFS_PGON:    n.pgon  = pwdata[15:0];
                OFS_OCL:     n.ocl   = pwdata[15:0];
                OFS_UCL:     n.ucl   = pwdata[15:0];
                OFS_RESP:    n.resp  = pwdata[4:0];
                OFS_PGDLY:   n.pgdly = pwdata[15:0];
                OFS_USERCFG:
                begin
                    n.pp    = pwdata[PP_BIT];
                    n.syncm = pwdata[SYNC_LSB +: 2];
                end
                OFS_ILV:     n.ilv   = pwdata[7:0];
                OFS_CLEAR:   n.flt   = r.flt & ~pwdata[3:0];
                default:     n.flt   = n.flt;
            endcase
        end

        n.vapp = applied;

        // power sequencing
        unique case (r.st)
            PW_OFF:
                if (r.init_done && en)
                    n.st = PW_RAMP;
            PW_RAMP:
                if (!en)
                    n.st = PW_OFF;
                else if (|f_now)
                    n.st = latch ? PW_LATCH : PW_HICCUP;
                else if (meas.vout_mv >= r.pgon)
                begin
                    n.st     = PW_ON;
                    n.pg_cnt = 16'h0000;
                    n.pg_ok  = 1'b1;
                end
            PW_ON:
                if (!en)
                    n.st = PW_OFF;
                else if (|f_now)
                    n.st = latch ? PW_LATCH : PW_HICCUP;
            PW_HICCUP:
                if (!en)
                    n.st = PW_OFF;
                else if (r.hic_cnt == 20'(HICCUP_CYCLES - 1))
                    n.st = PW_RAMP;
                else
                    n.hic_cnt = r.hic_cnt + 20'h0_0001;
            PW_LATCH:
                // leave on disable or on clear
                if (!en || (wr && paddr == OFS_CLEAR))
                    n.st = PW_OFF;
        endcase
        if (n.st == PW_HICCUP && r.st != PW_HICCUP)
            n.hic_cnt = 20'h0_0000;
        // sticky fault bits: a new fault wins over a clear
        n.flt = n.flt | f_now;

        // power good with delay and hysteresis
        if (r.st == PW_ON)
        begin
            if (r.pg_cnt != r.pgdly)
                n.pg_cnt = r.pg_cnt + 16'h0001;
            if (meas.vout_mv > r.pgon)
                n.pg_ok = 1'b1;
            else if (meas.vout_mv < r.uvl)
                n.pg_ok = 1'b0;
        end
        n.pg = (r.st == PW_ON) && (r.pg_cnt == r.pgdly) && n.pg_ok && !(|f_now);
        // open-drain releases for high, push-pull drives
        n.pg_out  = r.pp ? n.pg : 1'b0;
        n.pg_oe_n = r.pp ? 1'b0 : n.pg;

        // internal switching clock divider
        if (r.int_cnt >= 16'(SW_DIV / 2 - 1))
        begin
            n.int_cnt = 16'h0000;
            n.int_clk = !r.int_clk;
        end
        else
            n.int_cnt = r.int_cnt + 16'h0001;

        // phase placement within each sync period
        n.sync_prev = src;
        if (rise)
        begin
            n.period  = r.per_cnt + 16'h0001;
            n.per_cnt = 16'h0000;
            n.acc     = 24'h00_0000;
            n.fired_a = 1'b0;
            n.fired_b = 1'b0;
        end
        else
        begin
            n.per_cnt = r.per_cnt + 16'h0001;
            n.acc     = r.acc + 24'(grp16);
            if (!r.fired_a && r.acc >= tgt_a)
            begin
                n.fired_a = 1'b1;
                n.pwm_a   = (r.st == PW_RAMP || r.st == PW_ON);
            end
            if (!r.fired_b && {r.acc[22:0], 1'b0} >= tgt_b)
            begin
                n.fired_b = 1'b1;
                n.pwm_b   = (r.st == PW_RAMP || r.st == PW_ON);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r         <= '0;
            r.st      <= PW_OFF;
            r.onoff   <= ONOFF_RST;
            r.resp    <= RESP_RST;
            r.ocl     <= OCL_RST;
            r.ucl     <= UCL_RST;
            r.pgdly   <= PGDLY_RST_CYC;
            r.pg_oe_n <= 1'b0;
        end
        else
            r <= n;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata      = r.prdata;
    assign reg_en      = (r.st == PW_RAMP) || (r.st == PW_ON);
    assign vout_set    = r.vapp;
    assign pwm_a_start = r.pwm_a;
    assign pwm_b_start = r.pwm_b;
    assign sync_out    = (r.syncm == SYNC_OUT) && r.int_clk;
    assign sync_oe_n   = (r.syncm != SYNC_OUT);
    assign pg_out      = r.pg_out;
    assign pg_oe_n     = r.pg_oe_n;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_enable_starts: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == PW_OFF && r.init_done && en) |=> (r.st == PW_RAMP))
        else $error("enable did not start ramp");
    a_strap_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (r.init_done && $past(r.init_done)) |-> $stable(r.strap_mv))
        else $error("strap value changed after init");
    a_clamp_ceil: assert property (@(posedge pclk) disable iff (!presetn)
        r.init_done |=> (r.vapp <= $past(ceil)) && ($past(ceil) <= $past(r.ceil115)))
        else $error("applied set point above ceiling");
    a_ov_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == PW_ON && f_ov && en) |=> (r.st == PW_HICCUP || r.st == PW_LATCH) && !reg_en)
        else $error("over-voltage did not shut down");
    a_share_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (r.resp[RESP_SHARE] && (|f_now) && en) |=> (r.st == PW_LATCH))
        else $error("sharing fault did not latch");
    a_pg_only_on: assert property (@(posedge pclk) disable iff (!presetn)
        r.pg |-> ($past(r.st) == PW_ON) && ($past(r.pg_cnt) == $past(r.pgdly)))
        else $error("power good outside regulation or before delay");
    a_oc_after_ramp: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.flt[RESP_OC]) |-> ($past(r.st) == PW_ON))
        else $error("over-current flagged before ramp complete");
    a_hiccup_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (r.st == PW_RAMP && $past(r.st) == PW_HICCUP)
            |-> ($past(r.hic_cnt) == 20'(HICCUP_CYCLES - 1)))
        else $error("hiccup restart before interval");
    a_sync_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (r.syncm == SYNC_INT) |-> sync_oe_n && !sync_out && (src == r.int_clk))
        else $error("sync pin used in internal mode");
endmodule
`default_nettype wire

// ===== hdl/pos_pkg.sv
// package: register map, constants and types of the output supervisor
// Operation
// - output is enabled from the control pin or from the bus on bit, as configured.
// - control pin polarity is selectable active high or active low by register.
// - a control pin reported open reads as logic high.
// - strap decodes only to table entries; open gives 1.20 V, short 1.00 V.
// - strap is sampled once at initialization; later changes are ignored.
// - a set-point write replaces the strap nominal, still under the ceiling.
// - bus margin select picks nominal, low or high in pin and bus modes.
// - applied set point is the selected value plus signed trim.
// - applied output is clamped to 115% of strap; stored value reads back unchanged.
// - max register may lower the ceiling but never raise it above 115%.
// - over-voltage shuts down at once, then latches or hiccups; hiccup default.
// - under-voltage gives the same latch or hiccup response, hiccup default.
// - in current sharing every fault latches off whatever is configured.
// - power good low in ramp and faults; on above 90%, off below 85%.
// - power good assertion is delayed by a programmable time.
// - power good is open-drain by default, push-pull by configuration.
// - over-current is watched only after ramp-up; latch or hiccup, no delay.
// - reverse current beyond its limit responds like over-current.
// - second phase runs half a period later, doubling the effective rate.
// - sync pin is input or output; by default internal clock, pin ignored.
// - pulse lags sync rising edge by 360 degrees times order over group.
// - order and group are 4-bit; group zero means sixteen steps.
// - bus writes after initialization overwrite the initialized values.
package pos_pkg;
    localparam int CLK_MHZ = 10;
    localparam logic [7:0] OFS_OPERATION = 8'h00;
    localparam logic [7:0] OFS_ONOFF     = 8'h04;
    localparam logic [7:0] OFS_VCMD      = 8'h08;
    localparam logic [7:0] OFS_TRIM      = 8'h0c;
    localparam logic [7:0] OFS_VMAX      = 8'h10;
    localparam logic [7:0] OFS_MLOW      = 8'h14;
    localparam logic [7:0] OFS_MHIGH     = 8'h18;
    localparam logic [7:0] OFS_OVL       = 8'h1c;
    localparam logic [7:0] OFS_UVL       = 8'h20;
    localparam logic [7:0] OFS_PGON      = 8'h24;
    localparam logic [7:0] OFS_OCL       = 8'h28;
    localparam logic [7:0] OFS_UCL       = 8'h2c;
    localparam logic [7:0] OFS_RESP      = 8'h30;
    localparam logic [7:0] OFS_PGDLY     = 8'h34;
    localparam logic [7:0] OFS_USERCFG   = 8'h38;
    localparam logic [7:0] OFS_ILV       = 8'h3c;
    localparam logic [7:0] OFS_STATUS    = 8'h40;
    localparam logic [7:0] OFS_CLEAR     = 8'h44;
    localparam logic [7:0] OFS_VAPP      = 8'h48;
    localparam int OP_ON_BIT   = 0;
    localparam int OP_MRG_LSB  = 1;
    localparam int PIN_MODE_BIT = 0;
    localparam int PIN_POL_BIT = 1;
    localparam int RESP_OV     = 0;
    localparam int RESP_UV     = 1;
    localparam int RESP_OC     = 2;
    localparam int RESP_UC     = 3;
    localparam int RESP_SHARE  = 4;
    localparam int PP_BIT      = 0;
    localparam int SYNC_LSB    = 1;
    localparam int GRP_LSB     = 4;
    localparam logic [1:0] MRG_LOW   = 2'h1;
    localparam logic [1:0] MRG_HIGH  = 2'h2;
    localparam logic [1:0] SYNC_INT  = 2'h0;
    localparam logic [1:0] SYNC_IN   = 2'h1;
    localparam logic [1:0] SYNC_OUT  = 2'h2;
    localparam logic [1:0] ONOFF_RST = 2'h3;
    localparam logic [4:0] RESP_RST  = 5'h00;
    localparam logic [15:0] OCL_RST  = 16'h0578;
    localparam logic [15:0] UCL_RST  = 16'h00c8;
    localparam int PCT_MLOW  = 95;
    localparam int PCT_MHIGH = 105;
    localparam int PCT_OV    = 115;
    localparam int PCT_UV    = 85;
    localparam int PCT_PGON  = 90;
    localparam int PCT_CEIL  = 115;
    localparam int PGDLY_RST_US  = 1000;
    localparam logic [15:0] PGDLY_RST_CYC = 16'(PGDLY_RST_US * CLK_MHZ);
    localparam int HICCUP_US  = 10000;
    localparam int HICCUP_CYC = HICCUP_US * CLK_MHZ;
    localparam int SW_DIV_DEF = 20;
    localparam logic [15:0] STRAP_SHORT_MV = 16'h03e8;
    localparam logic [15:0] STRAP_OPEN_MV  = 16'h04b0;
    localparam logic [4:0]  STRAP_N        = 5'h14;
    localparam logic [15:0] STRAP_TAB [0:19] = '{
        16'h0258, 16'h028a, 16'h02bc, 16'h02ee, 16'h0320, 16'h0352, 16'h0384,
        16'h03b6, 16'h03e8, 16'h041a, 16'h044c, 16'h047e, 16'h04b0, 16'h04e2,
        16'h0514, 16'h0578, 16'h05dc, 16'h0640, 16'h06a4, 16'h0708};

    typedef enum logic [2:0] {PW_OFF, PW_RAMP, PW_ON, PW_HICCUP, PW_LATCH} pos_pwr_t;

    typedef struct packed {
        logic [15:0]        vout_mv;
        logic signed [15:0] iout;
    } pos_meas_t;

    // scale a millivolt value by a whole percentage
    function automatic logic [15:0] pos_pct(input logic [15:0] v, input int p);
        pos_pct = 16'((32'(v) * 32'(p)) / 32'd100);
    endfunction

    // strap index: 0 short, 1..20 table, above that open
    function automatic logic [15:0] pos_strap(input logic [4:0] code);
        if (code == 5'h00)
            pos_strap = STRAP_SHORT_MV;
        else if (code <= STRAP_N)
            pos_strap = STRAP_TAB[code - 5'h01];
        else
            pos_strap = STRAP_OPEN_MV;
    endfunction
endpackage

// ===== tb/pos_stage_model.sv
// power stage and sense model driven by the supervisor
`timescale 1ns/100ps
`default_nettype none
module pos_stage_model
    import pos_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        reg_en,
    input  wire logic [15:0] vout_set,
    input  wire logic [15:0] inj_mv,
    input  wire logic [15:0] inj_i,
    output var  pos_meas_t   meas
);
    logic [15:0] tgt;
    // output ramps 100 mv a cycle, drops at once; an injected level wins
    assign tgt = (inj_mv != 16'h0000) ? inj_mv : (reg_en ? vout_set : 16'h0000);
    always_ff @(posedge pclk)
    begin
        if (!presetn)
            meas <= '0;
        else
        begin
            meas.iout    <= inj_i;
            meas.vout_mv <= (tgt > meas.vout_mv + 16'h0064) ? meas.vout_mv + 16'h0064 : tgt;
        end
    end
endmodule
`default_nettype wire

// ===== tb/pol_output_supervisor_test.sv
// self-checking bench for the output supervisor
`timescale 1ns/100ps
`default_nettype none
module pol_output_supervisor_test;
    import pos_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, er, reg_en, pwa, pwb, sync_out, sync_oe_n, pg_out, pg_oe_n;
    logic [4:0]  strap_code = 5'h00, code;
    logic [2:0]  sph = 3'h0;
    logic        ctrl_pin = 1'b0, ctrl_pin_open = 1'b0, sync_in = 1'b0;
    logic [15:0] vout_set, inj_mv = 16'h0000, inj_i = 16'h0000;
    pos_meas_t   meas;
    int          bad_count = 0, checks = 0, s, c, i, na, nb;
    always #50 pclk = ~pclk;
    // free-running external sync, eight cycles a period
    always @(posedge pclk)
    begin
        sph <= sph + 3'h1;
        sync_in <= sph[2];
    end
    pos_supervisor #(.HICCUP_CYCLES(20), .SW_DIV(4)) pos_supervisor_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_code(strap_code), .ctrl_pin(ctrl_pin), .ctrl_pin_open(ctrl_pin_open),
        .meas(meas), .reg_en(reg_en), .vout_set(vout_set), .pwm_a_start(pwa),
        .pwm_b_start(pwb), .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
        .pg_out(pg_out), .pg_oe_n(pg_oe_n));
    pos_stage_model pos_stage_model_inst (.pclk(pclk), .presetn(presetn), .reg_en(reg_en),
        .vout_set(vout_set), .inj_mv(inj_mv), .inj_i(inj_i), .meas(meas));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int exp_strap(input logic [4:0] k);
        return (k == 5'h00) ? 1000 : (k <= 5'h14) ? int'(STRAP_TAB[k - 5'h01]) : 1200;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic wait_st(input logic [2:0] st);
        for (int n = 0; n < 60; n++)
        begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            if (rd[10:8] === st)
                break;
        end
        chk(rd[10:8], st);
    endtask
    // pulse shows two cycles after the sync rise seen here, plus the phase lag
    task automatic lag_chk(input logic [7:0] v);
        int r0;
        int ia;
        int ib;
        int e;
        logic p;
        apb(1'b1, OFS_ILV, v);
        e = 2 + 8 * int'(v[3:0]) / ((v[7:4] == 4'h0) ? 16 : int'(v[7:4]));
        r0 = -1;
        ia = -1;
        ib = -1;
        p = 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge pclk);
            if (k >= 16 && sync_in && !p && r0 < 0)
                r0 = k;
            if (r0 >= 0 && k > r0 && pwa && ia < 0)
                ia = k - r0;
            if (r0 >= 0 && k > r0 && pwb && ib < 0)
                ib = k - r0;
            p = sync_in;
        end
        chk(ia, e);
        chk(ib, e + 4);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(92266));
        for (i = 0; i < 3; i++)
        begin
            code = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom_range(20, 1));
            strap_code <= code;
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            s = exp_strap(code);
            rdchk(OFS_VCMD, s);
            strap_code <= code ^ 5'h03;
            rdchk(OFS_VCMD, s);
        end
        $display("test strap done");
        c = s * 115 / 100;
        rdchk(OFS_VMAX, c);
        rdchk(OFS_MLOW, s * 95 / 100);
        na = c + $urandom_range(100, 1);
        apb(1'b1, OFS_VCMD, na);
        rdchk(OFS_VCMD, na);
        rdchk(OFS_VAPP, c);
        chk(vout_set, c);
        apb(1'b1, OFS_VCMD, s - 50);
        rdchk(OFS_VAPP, s - 50);
        apb(1'b1, OFS_TRIM, -20);
        rdchk(OFS_VAPP, s - 70);
        apb(1'b1, OFS_TRIM, 0);
        apb(1'b1, OFS_VMAX, s - 100);
        rdchk(OFS_VAPP, s - 100);
        apb(1'b1, OFS_VMAX, c + 50);
        rdchk(OFS_VAPP, s - 50);
        apb(1'b1, OFS_VCMD, s);
        apb(1'b1, OFS_OPERATION, {MRG_LOW, 1'b0});
        rdchk(OFS_VAPP, s * 95 / 100);
        apb(1'b1, OFS_OPERATION, {MRG_HIGH, 1'b0});
        rdchk(OFS_VAPP, s * 105 / 100);
        apb(1'b1, OFS_OPERATION, 0);
        rdchk(8'h80, 0);
        chk(er, 1'b1);
        $display("test setpoint done");
        apb(1'b1, OFS_PGDLY, 3);
        ctrl_pin_open <= 1'b1;
        wait_st(3'h2);
        repeat (10) @(posedge pclk);
        chk(pg_oe_n, 1'b1);
        ctrl_pin_open <= 1'b0;
        wait_st(3'h0);
        apb(1'b1, OFS_ONOFF, 1);
        wait_st(3'h2);
        apb(1'b1, OFS_ONOFF, 0);
        wait_st(3'h0);
        apb(1'b1, OFS_OPERATION, 1);
        wait_st(3'h2);
        apb(1'b1, OFS_USERCFG, 1);
        repeat (10) @(posedge pclk);
        chk({pg_oe_n, pg_out, sync_oe_n}, 3'b011);
        na = 0;
        nb = 0;
        repeat (40) @(negedge pclk)
        begin
            na += int'(pwa);
            nb += int'(pwb);
        end
        chk(na > 0 && na == nb, 1'b1);
        apb(1'b1, OFS_USERCFG, 3);
        chk(sync_oe_n, 1'b1);
        lag_chk(8'h00);
        lag_chk(8'h02);
        lag_chk(8'h41);
        apb(1'b1, OFS_USERCFG, 5);
        chk(sync_oe_n, 1'b0);
        $display("test enable done");
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, OFS_RESP, 1 << i);
            inj_mv <= (i == 0) ? 16'(s * 6 / 5) : (i == 1) ? 16'h0001 : 16'h0000;
            inj_i <= (i == 2) ? OCL_RST + 16'h0001
                   : (i == 3) ? 16'h0000 - UCL_RST - 16'h0001 : 16'h0000;
            wait_st(3'h4);
            chk({pg_out, rd[4 + i]}, 2'b01);
            chk(reg_en, 1'b0);
            inj_mv <= 16'h0000;
            inj_i <= 16'h0000;
            apb(1'b1, OFS_CLEAR, 32'h0000_000f);
            wait_st(3'h2);
            chk(rd[7:4], 4'h0);
        end
        apb(1'b1, OFS_RESP, 0);
        inj_mv <= 16'(s * 6 / 5);
        wait_st(3'h3);
        inj_mv <= 16'h0000;
        wait_st(3'h2);
        apb(1'b1, OFS_RESP, 32'h0000_0010);
        inj_mv <= 16'h0001;
        wait_st(3'h4);
        $display("test faults done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
